// ### ris_consts.svh
// Constants for the reset initialization sequencer
`ifndef RIS_CONSTS_SVH
`define RIS_CONSTS_SVH
`define RIS_CLK_PERIOD_NS 25
`define RIS_IN_ASSERT_MIN 32
`define RIS_POR_ASSERT_MIN 32
`define RIS_OUT_ASSERT_MIN 512
`define RIS_HARD_TO_SOFT_MIN 16
`define RIS_CFG_SETUP_MIN 4
`define RIS_CFG_DRIVE_DELAY 1
`define RIS_PLL_LOCK_US 100
`define RIS_PLL_LOCK_CYC ((`RIS_PLL_LOCK_US * 1000) / `RIS_CLK_PERIOD_NS)
`define RIS_RST_SRC_W 3
`define RIS_CNT_W 13
`endif

// ### ris_pkg.sv
// Types for the reset initialization sequencer
package ris_pkg;
    typedef enum logic [2:0] {
        RIS_POR = 3'b000,
        RIS_PLL = 3'b001,
        RIS_HARD = 3'b010,
        RIS_SOFT = 3'b011,
        RIS_RUN = 3'b100
    } ris_state_t;
endpackage

// ### ris_reset_init_sequencer.sv
// Reset initialization sequencer: power-on, hard and soft reset flow
`timescale 1ns/10ps
`include "ris_consts.svh"

module ris_reset_init_sequencer
    import ris_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = `RIS_PLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hostMode,
    input wire logic power_on_reset_n,
    input wire logic hard_reset_in_n,
    input wire logic soft_reset_in_n,
    input wire logic [`RIS_RST_SRC_W-1:0] resetSourceIn,
    input wire logic input_clock_divider_select_in,
    output logic [`RIS_RST_SRC_W-1:0] resetSourceOut,
    output logic input_clock_divider_select_out,
    output logic configOe,
    output logic [`RIS_RST_SRC_W-1:0] resetSource,
    output logic input_clock_divider_select,
    output logic useDedicatedClock,
    output logic hard_reset_n,
    output logic hard_reset_oe,
    output logic soft_reset_n,
    output logic soft_reset_oe,
    output logic pllLocked
);
    // Two-stage synchronisers; stage one is read only by stage two
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic porLow;
    logic hardLow;
    logic softLow;
    // Reset value says every reset pin is held, so no false release follows rst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= 3'h7;
            syncB <= 3'h7;
        end else begin
            syncA <= {~soft_reset_in_n, ~hard_reset_in_n, ~power_on_reset_n};
            syncB <= syncA;
        end
    end
    assign porLow = syncB[0];
    assign hardLow = syncB[1];
    assign softLow = syncB[2];

    // Configuration pins pass through two register stages: the board holds them stable around release
    logic [`RIS_RST_SRC_W-1:0] cfgA, cfgB;
    logic divA, divB;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgA <= 3'h0;
            cfgB <= 3'h0;
            divA <= 1'b0;
            divB <= 1'b0;
        end else begin
            cfgA <= resetSourceIn;
            cfgB <= cfgA;
            divA <= input_clock_divider_select_in;
            divB <= divA;
        end
    end

    // Sequencer state
    ris_state_t state, next_state;
    logic [`RIS_CNT_W-1:0] cnt, next_cnt;
    logic [5:0] inCnt, next_inCnt;
    logic [`RIS_RST_SRC_W-1:0] next_resetSource;
    logic next_divSel;
    logic next_pllLocked;
    logic [`RIS_CNT_W-1:0] pllCnt, next_pllCnt;
    logic [1:0] cfgDly, next_cfgDly;
    logic inReq;

    // Any reset input low long enough starts the flow
    assign inReq = (porLow || hardLow || softLow) && (inCnt >= 6'(`RIS_IN_ASSERT_MIN));

    // Next-state logic
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_inCnt = (porLow || hardLow || softLow) ? ((inCnt == 6'h3F) ? inCnt : inCnt + 6'h01) : 6'h00;
        next_resetSource = resetSource;
        next_divSel = input_clock_divider_select;
        next_pllLocked = pllLocked;
        next_pllCnt = pllCnt;
        next_cfgDly = (state == RIS_HARD || state == RIS_POR) ? 2'h0 :
            ((cfgDly == 2'h2) ? cfgDly : cfgDly + 2'h1);
        unique case (state)
            RIS_POR: begin
                // Latch straps while power-on reset is held
                next_resetSource = cfgB;
                next_divSel = divB;
                next_pllLocked = 1'b0;
                next_pllCnt = '0;
                if (!porLow) begin
                    next_state = RIS_PLL;
                end
            end
            RIS_PLL: begin
                // Wait out PLL lock budget before trusting clocks
                if (pllCnt >= 13'(PLL_LOCK_CYCLES - 1)) begin
                    next_pllLocked = 1'b1;
                    next_state = RIS_HARD;
                    next_cnt = '0;
                end else begin
                    next_pllCnt = pllCnt + 13'h0001;
                end
            end
            RIS_HARD: begin
                // Hold both reset outputs at least the minimum
                if (cnt >= 13'(`RIS_OUT_ASSERT_MIN - 1) && !hardLow) begin
                    next_state = RIS_SOFT;
                    next_cnt = '0;
                end else if (cnt < 13'(`RIS_OUT_ASSERT_MIN - 1)) begin
                    next_cnt = cnt + 13'h0001;
                end
            end
            RIS_SOFT: begin
                // Soft reset lingers after hard reset release
                if (cnt >= 13'(`RIS_HARD_TO_SOFT_MIN - 1)) begin
                    next_state = RIS_RUN;
                end else begin
                    next_cnt = cnt + 13'h0001;
                end
            end
            RIS_RUN: begin
                // Re-enter sequence at once on power-on reset, or on a qualified hard or soft reset input
                if (porLow) begin
                    next_state = RIS_POR;
                end else if (inReq) begin
                    next_state = RIS_HARD;
                    next_cnt = '0;
                end
            end
            default: next_state = RIS_POR;
        endcase
        if (porLow && state != RIS_POR) begin
            next_state = RIS_POR;
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= RIS_POR;
            cnt <= '0;
            inCnt <= 6'h00;
            resetSource <= 3'h0;
            input_clock_divider_select <= 1'b0;
            pllLocked <= 1'b0;
            pllCnt <= '0;
            cfgDly <= 2'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            inCnt <= next_inCnt;
            resetSource <= next_resetSource;
            input_clock_divider_select <= next_divSel;
            pllLocked <= next_pllLocked;
            pllCnt <= next_pllCnt;
            cfgDly <= next_cfgDly;
        end
    end

    // Outputs: reset pins are open-drain style, driven low while asserted
    assign hard_reset_n = 1'b0;
    assign soft_reset_n = 1'b0;
    assign hard_reset_oe = (state != RIS_SOFT) && (state != RIS_RUN);
    assign soft_reset_oe = (state != RIS_RUN);
    // Config pins released combinationally on hard reset, so turn-off is immediate
    // Raw hard pin gates the enable: the synced copy lags two clocks, far too late
    assign configOe = (cfgDly == 2'h2) && !hard_reset_oe && !hardLow && hard_reset_in_n;
    assign resetSourceOut = resetSource;
    assign input_clock_divider_select_out = input_clock_divider_select;
    // Host mode uses dedicated input; agent mode uses bus clock
    assign useDedicatedClock = hostMode;

    // Cycles since the hard reset output let go; saturates so it never wraps
    logic [4:0] relCnt, next_relCnt;
    always_comb begin
        next_relCnt = hard_reset_oe ? 5'h00 : ((relCnt == 5'h1F) ? relCnt : relCnt + 5'h01);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            relCnt <= 5'h00;
        end else begin
            relCnt <= next_relCnt;
        end
    end

    // Assertions
    hard_min_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == RIS_HARD && cnt < 13'(`RIS_OUT_ASSERT_MIN - 1)) |=> hard_reset_oe)
        else $error("hard reset released early");
    sequence hardRelease;
        $fell(hard_reset_oe);
    endsequence
    soft_after_hard_a: assert property (@(posedge clk) disable iff (rst)
        $fell(soft_reset_oe) |-> relCnt >= 5'(`RIS_HARD_TO_SOFT_MIN))
        else $error("soft reset released too soon");
    cfg_off_hard_a: assert property (@(posedge clk) disable iff (rst)
        hard_reset_oe |-> !configOe)
        else $error("config driven during hard reset");
    cfg_on_delay_a: assert property (@(posedge clk) disable iff (rst)
        hardRelease |-> !configOe)
        else $error("config driven at hard release");
    pll_wait_a: assert property (@(posedge clk) disable iff (rst)
        $rose(pllLocked) |-> $past(state) == RIS_PLL)
        else $error("pll lock flagged outside wait");
    strap_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state == RIS_RUN && $past(state) == RIS_RUN) |-> $stable(resetSource))
        else $error("strap changed while running");
    in_qualify_a: assert property (@(posedge clk) disable iff (rst)
        (state == RIS_RUN ##1 state == RIS_HARD) |-> $past(inCnt) >= 6'(`RIS_IN_ASSERT_MIN))
        else $error("short reset pulse accepted");
    clk_select_a: assert property (@(posedge clk) disable iff (rst)
        useDedicatedClock == hostMode)
        else $error("clock select mismatch");
endmodule

// ### ris_board_model.sv
// Board reset supervisor and strap driver model
`timescale 1ns/10ps
module ris_board_model (
    input wire logic clk,
    input wire logic configOe,
    output logic power_on_reset_n,
    output logic hard_reset_in_n,
    output logic soft_reset_in_n,
    output logic [2:0] strapSrc,
    output logic strapDiv,
    output logic strapOe
);
    // Straps driven only while the device has let go of the pins
    assign strapOe = ~configOe;
    initial begin
        power_on_reset_n = 1'b0;
        hard_reset_in_n = 1'b1;
        soft_reset_in_n = 1'b1;
        strapSrc = 3'h0;
        strapDiv = 1'b0;
    end
    // Power-on pulse; straps settle first and hold past release
    task automatic porPulse(input int n, input logic [2:0] src, input logic div);
        @(negedge clk);
        strapSrc = src;
        strapDiv = div;
        power_on_reset_n = 1'b0;
        repeat (n) @(negedge clk);
        power_on_reset_n = 1'b1;
    endtask
    // Hard or soft input pulse of n cycles
    task automatic rstPulse(input logic hard, input int n);
        @(negedge clk);
        if (hard) hard_reset_in_n = 1'b0;
        else soft_reset_in_n = 1'b0;
        repeat (n) @(negedge clk);
        hard_reset_in_n = 1'b1;
        soft_reset_in_n = 1'b1;
    endtask
endmodule

// ### tb.sv
// Self-checking testbench for the reset sequencer
`timescale 1ns/10ps
module tb;
    localparam int PLLC = 8; // Short lock wait keeps runs brief
    logic clk, rst, hostMode;
    logic por, hIn, sIn, strapOe, strapDiv, divOut, configOe, div, useDed, hOut, hOe, sOut, sOe, pllLocked;
    logic [2:0] strapSrc, srcOut, src, pinSrc;
    logic pinDiv;
    logic prevHard = 1'b0;
    logic lastHIn = 1'b1;
    int num_errors = 0, comparisons = 0, hardCnt, softCnt, pllCnt;
    logic [31:0] seed = 32'h000003F8;
    // Shared pins: device, board, else pull-up
    assign pinSrc = configOe ? srcOut : (strapOe ? strapSrc : 3'h7);
    assign pinDiv = configOe ? divOut : (strapOe ? strapDiv : 1'b1);
    ris_board_model brd (.clk(clk), .configOe(configOe), .power_on_reset_n(por), .hard_reset_in_n(hIn),
        .soft_reset_in_n(sIn), .strapSrc(strapSrc), .strapDiv(strapDiv), .strapOe(strapOe));
    ris_reset_init_sequencer #(.PLL_LOCK_CYCLES(PLLC)) uut (.clk(clk), .rst(rst), .hostMode(hostMode),
        .power_on_reset_n(por), .hard_reset_in_n(hIn), .soft_reset_in_n(sIn), .resetSourceIn(pinSrc),
        .input_clock_divider_select_in(pinDiv), .resetSourceOut(srcOut), .input_clock_divider_select_out(divOut),
        .configOe(configOe), .resetSource(src), .input_clock_divider_select(div), .useDedicatedClock(useDed),
        .hard_reset_n(hOut), .hard_reset_oe(hOe), .soft_reset_n(sOut), .soft_reset_oe(sOe), .pllLocked(pllLocked));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Cycle monitor: phase lengths and pin ownership
    always @(negedge clk) begin
        if (!rst) begin
            if (hOe === 1'b1 && pllLocked === 1'b1) hardCnt++;
            if (hOe === 1'b0 && sOe === 1'b1) softCnt++;
            if (por === 1'b1 && pllLocked === 1'b0) pllCnt++;
            if (hOe !== 1'b0) check(configOe, 0);
            if (prevHard === 1'b1) check(configOe, 0);
            if (lastHIn === 1'b0) check(configOe, 0);
            check({hOut, sOut}, 0);
            prevHard = hOe;
            lastHIn = hIn;
        end
    end
    // Wait for the run state, then compare against the model
    task automatic waitRun(input logic [2:0] eSrc, input logic eDiv, input logic pll);
        int k;
        for (k = 0; k < 2000 && !(hOe === 1'b0 && sOe === 1'b0); k++) @(negedge clk);
        if (k == 2000) num_errors++;
        repeat (3) @(negedge clk);
        check(hardCnt >= 512, 1);
        check(softCnt, 16);
        if (pll) check(pllCnt >= PLLC && pllCnt <= PLLC + 4, 1);
        check({src, div}, {eSrc, eDiv});
        check({srcOut, divOut, configOe}, {eSrc, eDiv, 1'b1});
        check({useDed, pllLocked}, {hostMode, 1'b1});
        {hardCnt, softCnt, pllCnt} = '0;
    endtask
    initial begin
        logic [31:0] r;
        rst = 1'b1;
        hostMode = 1'b0;
        {hardCnt, softCnt, pllCnt} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (2) begin
            r = xs();
            hostMode = r[4];
            brd.porPulse(32 + r[9:6], r[2:0], r[3]);
            waitRun(r[2:0], r[3], 1'b1);
        end
        brd.rstPulse(1'b1, 10); // Short pulse is ignored
        repeat (6) @(negedge clk);
        check(hOe, 0);
        brd.rstPulse(1'b1, 40);
        waitRun(r[2:0], r[3], 1'b0);
        brd.rstPulse(1'b0, 40);
        waitRun(r[2:0], r[3], 1'b0);
        summarize();
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        summarize();
    end
endmodule
